// File: ssp_pkg.sv
// Package: constants, register map and carrier types for the sync serial port
package ssp_pkg;

	// ************************************************************
	// Register map (byte addresses)
	// ************************************************************
	localparam logic [7:0] SSP_CTRL_ADDR = 8'h00;
	localparam logic [7:0] SSP_TXDATA_ADDR = 8'h04;
	localparam logic [7:0] SSP_RXDATA_ADDR = 8'h08;
	localparam logic [7:0] SSP_STATUS_ADDR = 8'h0C;

	// Control register fields
	localparam int CTRL_TXCLK_SEL = 0;
	localparam int CTRL_FSDIR_SEL = 1;
	localparam int CTRL_FSX_GEN = 2;

	// Status register fields
	localparam int STAT_RXCLK_LVL = 0;
	localparam int STAT_TX_BUSY = 1;
	localparam int STAT_RX_BUSY = 2;
	localparam int STAT_RX_DONE = 3;
	localparam int STAT_PORT_IDLE = 4;

	// AXI responses
	localparam logic [1:0] SSP_RESP_OKAY = 2'h0;
	localparam logic [1:0] SSP_RESP_SLVERR = 2'h2;

	// Word width of the shift registers
	localparam int SSP_WORD_W = 16;

	// Master clock output half period is this count plus one ref_clk cycles
	localparam logic [1:0] SSP_MCLK_HALF = 2'h1;

	// Pin outputs carried together: value and enable
	typedef struct packed {
		logic dataOut;
		logic dataOutEn;
		logic txClk;
		logic txClkEn;
		logic txFs;
		logic txFsEn;
	} ssp_pins_s;

	// Synchronised pin inputs
	typedef struct packed {
		logic txClk;
		logic txFs;
		logic rxClk;
		logic rxFs;
		logic dataIn;
	} ssp_pin_in_s;

	typedef enum logic [1:0] {
		SSP_IDLE,
		SSP_ARMED,
		SSP_SHIFT
	} ssp_state_e;

endpackage : ssp_pkg

// File: ssp_sync2.sv
// Two-flop synchroniser for a group of pin inputs
module ssp_sync2
	import ssp_pkg::*;
#(
	parameter int W = 5
)
(
	// Clock and reset
	input wire logic ref_clk,
	input wire logic sys_rst,
	// Asynchronous input and synchronised output
	input wire logic [W-1:0] asyncIn,
	output logic [W-1:0] syncOut
);

	logic [W-1:0] stage1_r;

	// First stage feeds only the second
	always_ff @(posedge ref_clk)
	begin
		if (sys_rst)
		begin
			stage1_r <= '0;
			syncOut <= '0;
		end
		else
		begin
			stage1_r <= asyncIn;
			syncOut <= stage1_r;
		end
	end

endmodule // ssp_sync2

// File: ssp_port.sv
// Frame-synchronised serial port with AXI4-Lite registers
// Summary of operation
// RULE1 - Transmit shift register drives serial data out on transmit clock.
// RULE2 - Clock select 0: transmit clock pin is an input, partner clocks.
// RULE3 - Clock select 1: device drives transmit clock at half master clock.
// RULE4 - After reset the transmit clock pin is an input.
// RULE5 - Receive shift register takes serial data in on external clock.
// RULE6 - Partner keeps receive clock running for every whole receive.
// RULE7 - When idle, software reads receive clock pin level in status.
// RULE8 - Falling transmit frame sync starts the transmit shift.
// RULE9 - Frame sync is input after reset, output when direction bit is 1.
// RULE10 - Falling receive frame sync starts the receive shift.
// RULE11 - Float condition tristates data out, frame sync and clock.
// RULE12 - Tester holds test reset low and emulation pin a high.
// RULE13 - Emulation pin b low as float control tristates all outputs; the master clock output has no enable and stays driven.
// RULE14 - Transmit changes on rising clock; receive samples on falling.
//
// The implementer's own choices: the address map and register access over AXI4-Lite.
module ssp_port
	import ssp_pkg::*;
#(
	parameter int WORD_W = SSP_WORD_W
)
(
	// Clock and reset
	input wire logic ref_clk,
	input wire logic sys_rst,
	// AXI4-Lite write address and data
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	// AXI4-Lite write response
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// AXI4-Lite read
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// Serial pins
	input wire logic transmitBitClockIn,
	output logic transmitBitClockOut,
	output logic transmitBitClockOe,
	input wire logic transmitFrameSyncIn,
	output logic transmitFrameSyncOut,
	output logic transmitFrameSyncOe,
	input wire logic receiveBitClock,
	input wire logic receiveFrameSync,
	input wire logic serialDataIn,
	output logic serialDataOut,
	output logic serialDataOutOe,
	output logic masterClockOutput,
	// Test pins
	input wire logic testReset,
	input wire logic emulationPinA,
	input wire logic emulationPinBIn
);

	// ************************************************************
	// Pin synchronisers
	// ************************************************************
	ssp_pin_in_s pinSync;
	ssp_pin_in_s pinRaw;
	logic [2:0] testSync;
	assign pinRaw = '{txClk: transmitBitClockIn, txFs: transmitFrameSyncIn,
		rxClk: receiveBitClock, rxFs: receiveFrameSync,
		dataIn: serialDataIn};

	ssp_sync2 #(.W($bits(ssp_pin_in_s))) u_pinSync (
		.ref_clk(ref_clk),
		.sys_rst(sys_rst),
		.asyncIn(pinRaw),
		.syncOut(pinSync)
	);
	ssp_sync2 #(.W(3)) u_testSync (
		.ref_clk(ref_clk),
		.sys_rst(sys_rst),
		.asyncIn({testReset, emulationPinA, emulationPinBIn}),
		.syncOut(testSync)
	);

	// ************************************************************
	// Control registers and master clock
	// ************************************************************
	logic txClkSel_r, fsDir_r, fsGen_r;
	logic [WORD_W-1:0] txData_r, rxData_r;
	logic rxDone_r;
	logic [1:0] mclkCnt_r;
	logic mclk_r, intClk_r;

	// Master clock toggles every SSP_MCLK_HALF+1 cycles
	always_ff @(posedge ref_clk)
	begin
		if (sys_rst)
		begin
			mclkCnt_r <= 2'h0;
			mclk_r <= 1'b0;
		end
		else if (mclkCnt_r == SSP_MCLK_HALF)
		begin
			mclkCnt_r <= 2'h0;
			mclk_r <= ~mclk_r;
		end
		else
			mclkCnt_r <= mclkCnt_r + 2'h1;
	end

	// RULE3 half rate clock: toggles on each master clock rise
	wire mclkRise = (mclkCnt_r == SSP_MCLK_HALF) && !mclk_r;
	always_ff @(posedge ref_clk)
	begin
		if (sys_rst)
			intClk_r <= 1'b0;
		else if (mclkRise)
			intClk_r <= ~intClk_r;
	end

	// ************************************************************
	// Edge detection on effective clocks and frame syncs
	// ************************************************************
	logic txClkPrev_r, rxClkPrev_r, txFsPrev_r, rxFsPrev_r;
	logic fsOut_r;
	// RULE2 select clock source; input when select is 0
	wire txClkEff = txClkSel_r ? intClk_r : pinSync.txClk;
	wire txFsEff = fsDir_r ? fsOut_r : pinSync.txFs;
	wire txRise = txClkEff && !txClkPrev_r;
	wire rxFall = !pinSync.rxClk && rxClkPrev_r;
	// RULE8 falling transmit frame sync
	wire txFsFall = !txFsEff && txFsPrev_r;
	// RULE10 falling receive frame sync
	wire rxFsFall = !pinSync.rxFs && rxFsPrev_r;

	always_ff @(posedge ref_clk)
	begin
		if (sys_rst)
		begin
			// Synchronisers clear to 0, so a 1 here fakes a sync fall
			txClkPrev_r <= 1'b0;
			rxClkPrev_r <= 1'b0;
			txFsPrev_r <= 1'b0;
			rxFsPrev_r <= 1'b0;
		end
		else
		begin
			txClkPrev_r <= txClkEff;
			rxClkPrev_r <= pinSync.rxClk;
			txFsPrev_r <= txFsEff;
			rxFsPrev_r <= pinSync.rxFs;
		end
	end

	// ************************************************************
	// Transmit path
	// ************************************************************
	ssp_state_e txState_r;
	logic [WORD_W-1:0] txShift_r;
	logic [4:0] txCnt_r;
	logic txBit_r;
	wire txStart = fsGen_r && fsDir_r && txState_r == SSP_IDLE && txRise;

	// Generated frame sync: low pulse for one clock period
	always_ff @(posedge ref_clk)
	begin
		if (sys_rst)
			fsOut_r <= 1'b1;
		else if (txStart)
			fsOut_r <= 1'b0;
		else if (txRise)
			fsOut_r <= 1'b1;
	end

	// RULE1 shift out MSB first; RULE14 change on rising clock
	always_ff @(posedge ref_clk)
	begin
		if (sys_rst)
		begin
			txState_r <= SSP_IDLE;
			txShift_r <= '0;
			txCnt_r <= 5'h0;
			txBit_r <= 1'b0;
		end
		else
		begin
			unique case (txState_r)
				SSP_IDLE:
					if (txFsFall)
					begin
						txShift_r <= txData_r;
						txState_r <= SSP_SHIFT;
						txCnt_r <= 5'(WORD_W);
					end
				SSP_ARMED:
					txState_r <= SSP_SHIFT;
				SSP_SHIFT:
					if (txRise)
					begin
						txBit_r <= txShift_r[WORD_W-1];
						txShift_r <= {txShift_r[WORD_W-2:0], 1'b0};
						txCnt_r <= txCnt_r - 5'h1;
						if (txCnt_r == 5'h1)
							txState_r <= SSP_IDLE;
					end
			endcase
		end
	end

	// ************************************************************
	// Receive path
	// ************************************************************
	ssp_state_e rxState_r;
	logic [WORD_W-1:0] rxShift_r;
	logic [4:0] rxCnt_r;

	// RULE5 shift in on receive clock; RULE14 sample on falling edge
	always_ff @(posedge ref_clk)
	begin
		if (sys_rst)
		begin
			rxState_r <= SSP_IDLE;
			rxShift_r <= '0;
			rxCnt_r <= 5'h0;
			rxData_r <= '0;
		end
		else
		begin
			unique case (rxState_r)
				SSP_IDLE:
					if (rxFsFall)
					begin
						rxState_r <= SSP_SHIFT;
						rxCnt_r <= 5'(WORD_W);
					end
				SSP_ARMED:
					rxState_r <= SSP_SHIFT;
				SSP_SHIFT:
					if (rxFall)
					begin
						rxShift_r <= {rxShift_r[WORD_W-2:0], pinSync.dataIn};
						rxCnt_r <= rxCnt_r - 5'h1;
						if (rxCnt_r == 5'h1)
						begin
							rxState_r <= SSP_IDLE;
							rxData_r <= {rxShift_r[WORD_W-2:0], pinSync.dataIn};
						end
					end
			endcase
		end
	end
	wire rxWordDone = rxState_r == SSP_SHIFT && rxFall && rxCnt_r == 5'h1;

	// ************************************************************
	// Output pins and float condition
	// ************************************************************
	// RULE11 RULE12 float needs test reset low and emulation a high
	wire floatTest = !testSync[2] && testSync[1];
	// RULE13 emulation b low as float control tristates data, clock and sync
	wire floatAll = floatTest && !testSync[0];
	wire portIdle = txState_r == SSP_IDLE && rxState_r == SSP_IDLE;

	always_ff @(posedge ref_clk)
	begin
		if (sys_rst)
		begin
			serialDataOut <= 1'b0;
			serialDataOutOe <= 1'b0;
			transmitBitClockOut <= 1'b0;
			transmitBitClockOe <= 1'b0;
			transmitFrameSyncOut <= 1'b1;
			transmitFrameSyncOe <= 1'b0;
			masterClockOutput <= 1'b0;
		end
		else
		begin
			serialDataOut <= txBit_r;
			serialDataOutOe <= !floatAll;
			transmitBitClockOut <= intClk_r;
			// RULE4 clock pin stays input until select written
			transmitBitClockOe <= txClkSel_r && !floatAll;
			transmitFrameSyncOut <= fsOut_r;
			// RULE9 frame sync drives only when direction bit set
			transmitFrameSyncOe <= fsDir_r && !floatAll;
			masterClockOutput <= mclk_r;
		end
	end

	// ************************************************************
	// AXI4-Lite slave
	// ************************************************************
	logic awHeld_r, wHeld_r;
	logic [7:0] awAddr_r;
	logic [31:0] wData_r;
	wire doWrite = awHeld_r && wHeld_r && !s_axi_bvalid;
	wire wrCtrl = awAddr_r == SSP_CTRL_ADDR;
	wire wrTx = awAddr_r == SSP_TXDATA_ADDR;
	wire wrOk = wrCtrl || wrTx;

	// Read data selection; RULE7 pin level visible when idle
	logic [31:0] statusWord;
	assign statusWord = {27'h0, portIdle, rxDone_r,
		rxState_r != SSP_IDLE, txState_r != SSP_IDLE,
		portIdle & pinSync.rxClk};
	wire [31:0] rdMux =
		s_axi_araddr == SSP_CTRL_ADDR ? {29'h0, fsGen_r, fsDir_r, txClkSel_r} :
		s_axi_araddr == SSP_TXDATA_ADDR ? 32'(txData_r) :
		s_axi_araddr == SSP_RXDATA_ADDR ? 32'(rxData_r) :
		s_axi_araddr == SSP_STATUS_ADDR ? statusWord : 32'h0;
	wire rdOk = s_axi_araddr <= SSP_STATUS_ADDR && s_axi_araddr[1:0] == 2'h0;
	wire rdTake = s_axi_arvalid && s_axi_arready;

	// Write channel capture; address and data in either order
	always_ff @(posedge ref_clk)
	begin
		if (sys_rst)
		begin
			awHeld_r <= 1'b0;
			wHeld_r <= 1'b0;
			awAddr_r <= 8'h0;
			wData_r <= 32'h0;
		end
		else
		begin
			if (s_axi_awvalid && s_axi_awready)
			begin
				awHeld_r <= 1'b1;
				awAddr_r <= s_axi_awaddr;
			end
			else if (doWrite)
				awHeld_r <= 1'b0;
			if (s_axi_wvalid && s_axi_wready)
			begin
				wHeld_r <= 1'b1;
				wData_r <= s_axi_wdata;
			end
			else if (doWrite)
				wHeld_r <= 1'b0;
		end
	end

	// Handshake outputs and register writes
	always_ff @(posedge ref_clk)
	begin
		if (sys_rst)
		begin
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= SSP_RESP_OKAY;
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0;
			s_axi_rresp <= SSP_RESP_OKAY;
			txClkSel_r <= 1'b0;
			fsDir_r <= 1'b0;
			fsGen_r <= 1'b0;
			txData_r <= '0;
			rxDone_r <= 1'b0;
		end
		else
		begin
			s_axi_awready <= !awHeld_r && !s_axi_awready && !s_axi_bvalid;
			s_axi_wready <= !wHeld_r && !s_axi_wready && !s_axi_bvalid;
			if (doWrite)
			begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= wrOk ? SSP_RESP_OKAY : SSP_RESP_SLVERR;
				if (wrCtrl && s_axi_wstrb[0])
				begin
					txClkSel_r <= wData_r[CTRL_TXCLK_SEL];
					fsDir_r <= wData_r[CTRL_FSDIR_SEL];
					fsGen_r <= wData_r[CTRL_FSX_GEN];
				end
				if (wrTx)
					txData_r <= wData_r[WORD_W-1:0];
			end
			else if (s_axi_bready)
				s_axi_bvalid <= 1'b0;
			s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
			if (rdTake)
			begin
				s_axi_rvalid <= 1'b1;
				s_axi_rdata <= rdMux;
				s_axi_rresp <= rdOk ? SSP_RESP_OKAY : SSP_RESP_SLVERR;
			end
			else if (s_axi_rready)
				s_axi_rvalid <= 1'b0;
			// Done flag: set wins over read clear
			if (rxWordDone)
				rxDone_r <= 1'b1;
			else if (rdTake && s_axi_araddr == SSP_RXDATA_ADDR)
				rxDone_r <= 1'b0;
		end
	end

	// ************************************************************
	// Assertions
	// ************************************************************
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (sys_rst);

	tx_clk_dir_a: assert property (!txClkSel_r |=> !transmitBitClockOe) // RULE2
		else $error("transmit clock driven while select is 0");
	tx_clk_rate_a: assert property (txClkSel_r && mclkRise |=> // RULE3
		intClk_r != $past(intClk_r))
		else $error("internal transmit clock missed master rise");
	fs_dir_a: assert property (!fsDir_r |=> !transmitFrameSyncOe) // RULE9
		else $error("frame sync driven while direction is input");
	tx_start_a: assert property (txState_r == SSP_IDLE && txFsFall |=> // RULE8
		txState_r == SSP_SHIFT && txShift_r == $past(txData_r))
		else $error("transmit did not start on frame sync fall");
	rx_start_a: assert property (rxState_r == SSP_IDLE && rxFsFall |=> // RULE10
		rxState_r == SSP_SHIFT)
		else $error("receive did not start on frame sync fall");
	rx_shift_a: assert property (rxState_r == SSP_SHIFT && rxFall && // RULE5
		rxCnt_r > 5'h1 |=> rxShift_r[0] == $past(pinSync.dataIn))
		else $error("receive bit not captured");
	tx_shift_a: assert property (txState_r == SSP_SHIFT && txRise |=> // RULE1
		txBit_r == $past(txShift_r[WORD_W-1]) ##1
		serialDataOut == $past(txBit_r))
		else $error("transmit bit not driven");
	rx_lvl_a: assert property (rdTake && s_axi_araddr == SSP_STATUS_ADDR |=> // RULE7
		s_axi_rdata[STAT_RXCLK_LVL] == ($past(portIdle) && $past(pinSync.rxClk)))
		else $error("clock level wrong in status read");
	float_a: assert property (floatAll |=> !serialDataOutOe && // RULE11
		!transmitFrameSyncOe && !transmitBitClockOe)
		else $error("outputs driven during float condition");
	rx_edge_a: assert property (rxCnt_r != $past(rxCnt_r) && // RULE14
		$past(rxState_r) == SSP_SHIFT |-> $past(rxFall))
		else $error("receive count moved off falling edge");

	tx_word_c: cover property (txState_r == SSP_SHIFT ##1
		txState_r == SSP_IDLE);
	rx_word_c: cover property (rxWordDone);
	float_c: cover property (floatAll);
	int_clk_c: cover property (transmitBitClockOe && fsGen_r);

endmodule // ssp_port

// File: ssp_codec_model.sv
// Behavioural serial codec on the far side of the sync serial port
module ssp_codec_model
(
	// Requests from the bench
	input wire logic go,
	input wire logic idleLvl,
	input wire logic [15:0] rxWord,
	// Device transmit data
	input wire logic dataOut,
	// Link pins driven by the codec
	output logic txClk,
	output logic txFs,
	output logic rxClk,
	output logic rxFs,
	output logic dataIn,
	// Captured transmit word
	output logic [15:0] capWord,
	output logic capDone
);
	timeunit 1ns;
	timeprecision 1ps;
	logic clk = 1'b0;
	logic inFrame = 1'b0;
	// codec supplies clock
	// Clocks stand still outside frames
	assign txClk = inFrame ? clk : idleLvl;
	assign rxClk = inFrame ? clk : idleLvl;
	// One full-duplex frame per request, 80 ns link clock
	initial
	begin
		txFs = 1'b1;
		rxFs = 1'b1;
		dataIn = 1'b0;
		capWord = 16'h0000;
		capDone = 1'b0;
		forever
		begin
			@(posedge go);
			// Odd offset keeps link phase unrelated
			#3;
			inFrame = 1'b1;
			txFs = 1'b0;
			rxFs = 1'b0;
			#40;
			for (int i = 15; i >= 0; i--)
			begin
				clk = 1'b1;
				dataIn = rxWord[i];
				#40;
				clk = 1'b0;
				capWord[i] = dataOut;
				if (i == 15)
				begin
					txFs = 1'b1;
					rxFs = 1'b1;
				end
				#40;
			end
			inFrame = 1'b0;
			// Released line must not keep its last bit
			dataIn = ~dataIn;
			capDone = 1'b1;
			wait (!go);
			capDone = 1'b0;
		end
	end
endmodule // ssp_codec_model

// File: sync_serial_port_pins_bench.sv
// Self-checking bench for the sync serial port pins
module sync_serial_port_pins_bench import ssp_pkg::*;;
	timeunit 1ns;
	timeprecision 1ps;
	typedef struct packed {
		logic [31:0] exp;
		logic [31:0] mask;
		logic [1:0] resp;
	} ssp_rd_s;
	logic ref_clk = 1'b0;
	logic sys_rst = 1'b1;
	logic [7:0] s_axi_awaddr = 8'h00;
	logic [7:0] s_axi_araddr = 8'h00;
	logic [31:0] s_axi_wdata = 32'h0;
	logic [3:0] s_axi_wstrb = 4'hF;
	logic s_axi_awvalid = 1'b0;
	logic s_axi_wvalid = 1'b0;
	logic s_axi_bready = 1'b0;
	logic s_axi_arvalid = 1'b0;
	logic s_axi_rready = 1'b0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid;
	logic s_axi_arready, s_axi_rvalid;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic [31:0] s_axi_rdata;
	logic txClkOut, txClkOe, fsOut, fsOe, dataOut, dataOutOe, mclk;
	logic mTxClk, mTxFs, mRxClk, mRxFs, mDataIn, capDone;
	logic capPrev = 1'b0;
	logic [15:0] capWord;
	logic testReset = 1'b1;
	logic emuA = 1'b0;
	logic emuB = 1'b1;
	logic go = 1'b0;
	logic idleLvl = 1'b0;
	logic [15:0] rxWord = 16'h0000;
	logic [15:0] txw;
	logic pM, pT;
	logic pClk = 1'b0;
	logic [4:0] genCnt = 5'h0;
	logic [15:0] genWord = 16'h0;
	logic [31:0] gExp;
	logic [15:0] genQ[$];
	ssp_rd_s rdQ[$];
	ssp_rd_s cur;
	logic [1:0] bQ[$];
	logic [15:0] capQ[$];
	int n_mismatch = 0;
	int n_checks = 0;
	integer seed = 32'h67AB9033;
	int n, nM, nT;
	// Pin level: device wins while its enable is high
	wire txClkPin = txClkOe ? txClkOut : mTxClk;
	wire fsPin = fsOe ? fsOut : mTxFs;

	// ****************
	// Clock, design, partner
	// ****************
	initial
	begin
		forever #2.5 ref_clk = ~ref_clk;
	end
	ssp_port u_dut (.ref_clk(ref_clk), .sys_rst(sys_rst),
		.s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
		.s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
		.s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
		.s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
		.s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
		.s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
		.s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
		.s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
		.s_axi_rready(s_axi_rready), .transmitBitClockIn(txClkPin),
		.transmitBitClockOut(txClkOut), .transmitBitClockOe(txClkOe),
		.transmitFrameSyncIn(fsPin), .transmitFrameSyncOut(fsOut),
		.transmitFrameSyncOe(fsOe), .receiveBitClock(mRxClk),
		.receiveFrameSync(mRxFs), .serialDataIn(mDataIn),
		.serialDataOut(dataOut), .serialDataOutOe(dataOutOe),
		.masterClockOutput(mclk), .testReset(testReset),
		.emulationPinA(emuA), .emulationPinBIn(emuB));
	ssp_codec_model u_codec (.go(go), .idleLvl(idleLvl),
		.rxWord(rxWord), .dataOut(dataOut), .txClk(mTxClk),
		.txFs(mTxFs), .rxClk(mRxClk), .rxFs(mRxFs), .dataIn(mDataIn),
		.capWord(capWord), .capDone(capDone));

	// ****************
	// Compare, wait and bus tasks
	// ****************
	task automatic cmp_val(input string what, input logic [31:0] e,
		input logic [31:0] g);
		n_checks++;
		if (g !== e)
		begin
			n_mismatch++;
			$display("BAD %s expected %h seen %h", what, e, g);
		end
	endtask
	task automatic cmp_pin(input string what, input logic e,
		input logic g);
		cmp_val(what, {31'h0, e}, {31'h0, g});
	endtask
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", n_checks, n_mismatch);
		if (n_mismatch == 0 && n_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	// One clock of a bounded wait; an empty budget ends the run
	task automatic step(ref int left);
		@(posedge ref_clk);
		left--;
		if (left <= 0)
		begin
			n_mismatch++;
			$display("BAD wait expected done seen timeout");
			end_of_test();
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d,
		input logic [1:0] r);
		int k;
		k = 200;
		bQ.push_back(r);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do
		begin
			step(k);
			if (s_axi_awready === 1'b1)
				s_axi_awvalid <= 1'b0;
			if (s_axi_wready === 1'b1)
				s_axi_wvalid <= 1'b0;
		end while (s_axi_bvalid !== 1'b1);
		s_axi_bready <= 1'b0;
		@(posedge ref_clk);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e,
		input logic [31:0] m, input logic [1:0] r);
		int k;
		k = 200;
		rdQ.push_back('{e, m, r});
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do
		begin
			step(k);
			if (s_axi_arready === 1'b1)
				s_axi_arvalid <= 1'b0;
		end while (s_axi_rvalid !== 1'b1);
		s_axi_rready <= 1'b0;
		@(posedge ref_clk);
	endtask

	// Scoreboard: oldest note meets each result as it appears
	always @(posedge ref_clk)
	begin
		capPrev <= capDone;
		pClk <= txClkOut;
		if (s_axi_rvalid === 1'b1 && s_axi_rready === 1'b1)
		begin
			cur = rdQ.pop_front();
			cmp_val("rdata", cur.exp, s_axi_rdata & cur.mask);
			cmp_val("rresp", {30'h0, cur.resp}, {30'h0, s_axi_rresp});
		end
		if (s_axi_bvalid === 1'b1 && s_axi_bready === 1'b1)
			cmp_val("bresp", {30'h0, bQ.pop_front()}, {30'h0, s_axi_bresp});
		if (capDone === 1'b1 && capPrev === 1'b0)
			cmp_val("txWord", {16'h0, capQ.pop_front()}, {16'h0, capWord});
		// Device-timed frame: bits read on pin clock falls once sync is up
		if (fsOe === 1'b1 && fsOut === 1'b0)
		begin
			genCnt <= 5'h10;
			genWord <= 16'h0;
		end
		else if (genCnt != 5'h0 && txClkOe === 1'b1 && txClkOut === 1'b0
			&& pClk === 1'b1)
		begin
			genWord <= {genWord[14:0], dataOut};
			genCnt <= genCnt - 5'h1;
			if (genCnt == 5'h1)
			begin
				gExp = {16'h0, genQ.pop_front()};
				cmp_val("genWord", gExp, {15'h0, genWord, dataOut});
			end
		end
	end

	// ****************
	// Main sequence
	// ****************
	initial
	begin
		repeat (3) @(posedge ref_clk);
		sys_rst <= 1'b0;
		@(posedge ref_clk);
		cmp_pin("txClkOe", 1'b0, txClkOe);
		cmp_pin("fsOe", 1'b0, fsOe);
		// Idle receive clock level seen in status, both levels
		for (int v = 1; v >= 0; v--)
		begin
			idleLvl <= v[0];
			repeat (6) @(posedge ref_clk);
			rd(SSP_STATUS_ADDR, {31'h0, v[0]}, 32'h1, SSP_RESP_OKAY);
		end
		rd(8'h10, 32'h0, 32'hFFFFFFFF, SSP_RESP_SLVERR);
		wr(8'h14, 32'h3, SSP_RESP_SLVERR);
		wr(SSP_CTRL_ADDR, 32'h3, SSP_RESP_OKAY);
		repeat (4) @(posedge ref_clk);
		cmp_pin("txClkOe", 1'b1, txClkOe);
		cmp_pin("fsOe", 1'b1, fsOe);
		// Toggle counts over 64 cycles fix both clock rates
		nM = 0;
		nT = 0;
		pM = mclk;
		pT = txClkOut;
		repeat (64)
		begin
			@(posedge ref_clk);
			if (mclk !== pM)
				nM++;
			if (txClkOut !== pT)
				nT++;
			pM = mclk;
			pT = txClkOut;
		end
		cmp_val("mclkToggles", 32'h20, nM);
		cmp_val("txClkToggles", 32'h10, nT);
		testReset <= 1'b0;
		emuA <= 1'b1;
		emuB <= 1'b0;
		repeat (6) @(posedge ref_clk);
		cmp_pin("txClkOe", 1'b0, txClkOe);
		cmp_pin("fsOe", 1'b0, fsOe);
		cmp_pin("dataOutOe", 1'b0, dataOutOe);
		testReset <= 1'b1;
		emuA <= 1'b0;
		emuB <= 1'b1;
		repeat (6) @(posedge ref_clk);
		cmp_pin("txClkOe", 1'b1, txClkOe);
		cmp_pin("fsOe", 1'b1, fsOe);
		cmp_pin("dataOutOe", 1'b1, dataOutOe);
		// Back-to-back full-duplex frames on the codec's clock
		wr(SSP_CTRL_ADDR, 32'h0, SSP_RESP_OKAY);
		for (int f = 0; f < 3; f++)
		begin
			txw = 16'($random(seed));
			rxWord <= 16'($random(seed));
			wr(SSP_TXDATA_ADDR, {16'h0, txw}, SSP_RESP_OKAY);
			capQ.push_back(txw);
			go <= 1'b1;
			n = 400;
			while (capDone !== 1'b1)
				step(n);
			go <= 1'b0;
			rd(SSP_RXDATA_ADDR, {16'h0, rxWord}, 32'hFFFF, SSP_RESP_OKAY);
		end
		// Frame timed by the device: own clock and generated sync
		txw = 16'($random(seed));
		genQ.push_back(txw);
		wr(SSP_TXDATA_ADDR, {16'h0, txw}, SSP_RESP_OKAY);
		wr(SSP_CTRL_ADDR, 32'h7, SSP_RESP_OKAY);
		n = 400;
		while (genQ.size() != 0)
			step(n);
		wr(SSP_CTRL_ADDR, 32'h0, SSP_RESP_OKAY);
		repeat (4) @(posedge ref_clk);
		end_of_test();
	end
endmodule // sync_serial_port_pins_bench
